// File: verilog/wmis_pkg.sv
package wmis_pkg;
  localparam int NUM_QUEUES = 10;
  localparam int NUM_TIMERS = 16;
  localparam int NUM_BANKS = 6;
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;
  // register byte addresses
  localparam logic [31:0] ADDR_PRIM_FLAGS = 32'h1000_0080;
  localparam logic [31:0] ADDR_BANK0 = 32'h1000_0084;
  localparam logic [31:0] ADDR_BANK1 = 32'h1000_0088;
  localparam logic [31:0] ADDR_BANK2 = 32'h1000_008C;
  localparam logic [31:0] ADDR_BANK3 = 32'h1000_0090;
  localparam logic [31:0] ADDR_BANK4 = 32'h1000_0094;
  localparam logic [31:0] ADDR_BANK5 = 32'h1000_0098;
  localparam logic [31:0] ADDR_PRIM_MASK = 32'h1000_00A0;
  localparam logic [31:0] ADDR_BANK_MASK0 = 32'h1000_00A4;
  localparam logic [31:0] ADDR_STRIDE = 32'h0000_0004;
  // per-queue field positions inside a bank
  localparam int Q_LO = 0;
  localparam int Q_HI = 16;
  // implemented bits of each bank
  localparam logic [31:0] BANK_Q_VALID = 32'h03FF_03FF;
  localparam logic [31:0] BANK2_VALID = 32'hFFC0_03FF;
  localparam logic [31:0] BANK4_VALID = 32'h0000_03FF;
  localparam logic [31:0] BANK5_VALID = 32'hFFFF_FFFF;
  // bank 2 beacon field positions
  localparam int B2_CS_TMO = 22;
  localparam int B2_TX_TMO = 23;
  localparam int B2_TIM = 24;
  localparam int B2_BEND = 25;
  localparam int B2_DSYNC = 26;
  localparam int B2_BCN_WAIT = 27;
  localparam int B2_BTO = 28;
  localparam int B2_DMAP = 29;
  localparam int B2_TSF = 30;
  localparam int B2_TBTT = 31;
  // primary bit positions
  localparam int P_RX_MIT = 31;
  localparam int P_TX_MIT = 30;
  localparam int P_GEN_TMR = 28;
  localparam int P_SCHED = 27;
  localparam int P_QEMPTY = 26;
  localparam int P_QOVF = 25;
  localparam int P_RX_MAX = 24;
  localparam int P_BCN_MISC = 23;
  localparam int P_TX_MAX = 19;
  localparam int P_URN = 11;
  localparam int P_TX_EOL = 10;
  localparam int P_TX_ERR = 8;
  localparam int P_TX_DESC = 7;
  localparam int P_TX_OK = 6;
  // primary bits set directly by an event input
  localparam logic [31:0] DIRECT_MASK = 32'hE057_F23F;
endpackage

// File: verilog/wmis_tmr_if.sv
`timescale 1ns/1ps
interface wmis_tmr_if #(
  parameter int NT = 16,
  parameter int W = 32
);
  logic [W-1:0] tsf;
  logic [NT*W-1:0] timer_value;
  logic [NT*W-1:0] period;
  logic [W-1:0] late_margin;
  logic [NT-1:0] enable;
  logic [NT-1:0] trig;
  logic [NT-1:0] thr;
  logic ovf;
  modport cmp(input tsf, timer_value, period, late_margin, enable,
    output trig, thr, ovf);
  modport agg(output tsf, timer_value, period, late_margin, enable,
    input trig, thr, ovf);
endinterface

// File: verilog/wmis_gen_timer_cmp.sv
`timescale 1ns/1ps
module wmis_gen_timer_cmp #(
  parameter int NT = 16,
  parameter int W = 32
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  wmis_tmr_if.cmp tif
);
  logic [NT-1:0] trig_c;
  logic [NT-1:0] thr_c;
  logic [NT-1:0] ovf_c;
  logic [NT-1:0] trig_prev_r;
  logic [NT-1:0] thr_prev_r;
  logic [NT-1:0] ovf_prev_r;
  logic [W:0] ts_x;
  logic [W:0] lm_x;

  assign ts_x = {1'b0, tif.tsf};
  assign lm_x = {1'b0, tif.late_margin};

  for (genvar i = 0; i < NT; i++) begin : g_tmr
    logic [W:0] tv;
    logic [W:0] pv;
    assign tv = {1'b0, tif.timer_value[i*W +: W]};
    assign pv = {1'b0, tif.period[i*W +: W]};
    // wide sums so a late timer never wraps into a false match
    assign trig_c[i] = tif.enable[i] && (ts_x >= tv);
    assign thr_c[i] = tif.enable[i] && (ts_x >= (W+1)'(tv + lm_x));
    assign ovf_c[i] = tif.enable[i] && (ts_x >= (W+1)'(tv + pv));
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_prev_r <= '0;
      thr_prev_r <= '0;
      ovf_prev_r <= '0;
    end else begin
      trig_prev_r <= trig_c;
      thr_prev_r <= thr_c;
      ovf_prev_r <= ovf_c;
    end
  end

  // one event per crossing, not per cycle the condition holds
  assign tif.trig = trig_c & ~trig_prev_r;
  assign tif.thr = thr_c & ~thr_prev_r;
  assign tif.ovf = |(ovf_c & ~ovf_prev_r);
endmodule

// File: verilog/wmis_irq_status.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
// Overview of operation
// - primary bit 28 ORs all masked general_timer flags of bank 5
// - primary bit 27 ORs masked queue scheduling-trigger flags of bank 4
// - bit 26 ORs empty-queue triggers, bit 25 expired-count overflows
// - bit 23 ORs the ten beacon and timeout flags of bank 2
// - bit 24 needs rx mitigation plus max-rate; alternates with bit 19
// - bit 11 ORs per-queue transmit underrun flags of bank 2
// - bit 10 ORs out-of-descriptor flags, bit 8 error completions
// - bit 6 ORs clean completions, bit 7 requested-interrupt completions
// - bit 20 flags beacon alert on an empty beacon queue
// - bits 18 to 14 flag beacon, key-lookup and phy events
// - bits 5 to 0 flag receive overrun, exhaustion, timeout, completions
// - bank 0: requested-done at 16+n, clean at n, write-one-clear
// - bank 1: out-of-descriptors at 16+n, error at n, write-one-clear
// - bank 2 bits 31, 30, 24: beacon timer, timestamp range, map hit
// - bank 2 bit 29 only for delivery beacon with count zero
// - bit 28 timeout without final frame; bit 27 beacon wait timeout
// - bit 26 delivery-map mismatch; bit 25 final broadcast frame
// - bits 23, 22 when count first reaches or passes limit; bits 9:0 underruns
// - bank 3: empty-trigger at 16+n, expired overflow at n
// - bank 4: scheduling trigger of queue n at bit n
// - bank 5: thresholds 17-31, overflow 16, triggers 0-15
// - trigger, threshold and overflow come from timestamp comparisons
// - writing one to an aggregate bit clears its source flags
// - aggregates OR source flags only after secondary masking
// - interrupt output goes high the cycle after primary status and mask overlap
// - bank 5 bit 0 holds the trigger of timer 0
module wmis_irq_status
  import wmis_pkg::*;
#(
  parameter int NQ = NUM_QUEUES,
  parameter int NT = NUM_TIMERS,
  parameter int TW = 32,
  parameter int CW = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mac_irq,
  input wire logic [31:0] direct_event,
  input wire logic rx_max_rate_reached,
  input wire logic tx_max_rate_reached,
  input wire logic [NQ-1:0] tx_done_clean,
  input wire logic [NQ-1:0] tx_requested_done,
  input wire logic [NQ-1:0] tx_done_with_error,
  input wire logic [NQ-1:0] tx_descriptors_exhausted,
  input wire logic [NQ-1:0] tx_fifo_underrun,
  input wire logic [NQ-1:0] queue_empty_trigger,
  input wire logic [NQ-1:0] queue_expired_overflow,
  input wire logic [NQ-1:0] queue_sched_trigger,
  input wire logic beacon_time_timer_expired,
  input wire logic timestamp_out_of_range,
  input wire logic delivery_map_beacon,
  input wire logic [7:0] delivery_count,
  input wire logic broadcast_after_beacon_due,
  input wire logic broadcast_wait_expired,
  input wire logic beacon_wait_timeout,
  input wire logic delivery_map_sync_lost,
  input wire logic broadcast_traffic_end,
  input wire logic traffic_map_hit,
  input wire logic [CW-1:0] global_tx_count,
  input wire logic [CW-1:0] global_tx_limit,
  input wire logic [CW-1:0] carrier_sense_count,
  input wire logic [CW-1:0] carrier_sense_limit,
  input wire logic [TW-1:0] timestamp,
  input wire logic [NT*TW-1:0] general_timer,
  input wire logic [NT*TW-1:0] general_timer_period,
  input wire logic [TW-1:0] general_timer_late_margin,
  input wire logic [NT-1:0] general_timer_enable
);
  localparam logic [31:0] QV = BANK_Q_VALID;
  localparam logic [31:0] BANK_VALID [NUM_BANKS] =
    '{QV, QV, BANK2_VALID, QV, BANK4_VALID, BANK5_VALID};

  logic [31:0] sec_r [NUM_BANKS];
  logic [31:0] sec_mask_r [NUM_BANKS];
  logic [31:0] sec_set [NUM_BANKS];
  logic [31:0] sec_clr [NUM_BANKS];
  logic [31:0] sec_m [NUM_BANKS];
  logic [31:0] prim_direct_r;
  logic [31:0] prim_mask_r;
  logic [31:0] prim_val;
  logic [31:0] prim_pw;
  logic [31:0] direct_set;
  logic [31:0] rd_nxt;
  logic [NQ-1:0] q0;
  logic acc;
  logic wr;
  logic setup;
  logic hit;
  logic rx_max;
  logic tx_max;
  logic rx_max_win;
  logic tx_max_win;
  logic alt_r;
  logic bab_end_seen_r;
  logic tx_tmo_hit_r;
  logic cs_tmo_hit_r;
  logic tx_tmo_hit;
  logic cs_tmo_hit;
  logic irq_nxt;

  wmis_tmr_if #(.NT(NT), .W(TW)) tif();

  assign tif.tsf = timestamp;
  assign tif.timer_value = general_timer;
  assign tif.period = general_timer_period;
  assign tif.late_margin = general_timer_late_margin;
  assign tif.enable = general_timer_enable;

  wmis_gen_timer_cmp #(.NT(NT), .W(TW)) u_tmr (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tif(tif.cmp)
  );

  // apb: setup cycle loads read data and raises pready for the access
  assign setup = psel && !penable;
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign q0 = '0;

  always_comb begin
    hit = 1'b1;
    rd_nxt = RESET_VAL;
    if (paddr == ADDR_PRIM_FLAGS) begin
      rd_nxt = prim_val;
    end else if (paddr == ADDR_PRIM_MASK) begin
      rd_nxt = prim_mask_r;
    end else begin
      hit = 1'b0;
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (paddr == ADDR_BANK0 + ADDR_STRIDE * b) begin
          hit = 1'b1;
          rd_nxt = sec_r[b];
        end
        if (paddr == ADDR_BANK_MASK0 + ADDR_STRIDE * b) begin
          hit = 1'b1;
          rd_nxt = sec_mask_r[b];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RESET_VAL;
    end else begin
      pready <= setup;
      pslverr <= setup && !hit;
      prdata <= (setup && !pwrite) ? rd_nxt : RESET_VAL;
    end
  end

  // secondary event sources, one bank per entry
  assign sec_set[0] = {6'h00, tx_requested_done, 6'h00,
    tx_done_clean};
  assign sec_set[1] = {6'h00, tx_descriptors_exhausted, 6'h00,
    tx_done_with_error};
  assign tx_tmo_hit = global_tx_count >= global_tx_limit;
  assign cs_tmo_hit = carrier_sense_count >= carrier_sense_limit;
  always_comb begin
    sec_set[2] = '0;
    sec_set[2][NQ-1:0] = tx_fifo_underrun;
    sec_set[2][B2_TBTT] = beacon_time_timer_expired;
    sec_set[2][B2_TSF] = timestamp_out_of_range;
    sec_set[2][B2_DMAP] = delivery_map_beacon &&
      (delivery_count == 8'h00);
    sec_set[2][B2_BTO] = broadcast_wait_expired &&
      !bab_end_seen_r && !broadcast_traffic_end;
    sec_set[2][B2_BCN_WAIT] = beacon_wait_timeout;
    sec_set[2][B2_DSYNC] = delivery_map_sync_lost;
    sec_set[2][B2_BEND] = broadcast_traffic_end;
    sec_set[2][B2_TIM] = traffic_map_hit;
    sec_set[2][B2_TX_TMO] = tx_tmo_hit && !tx_tmo_hit_r;
    sec_set[2][B2_CS_TMO] = cs_tmo_hit && !cs_tmo_hit_r;
  end
  assign sec_set[3] = {6'h00, queue_empty_trigger, 6'h00,
    queue_expired_overflow};
  assign sec_set[4] = {22'h000000, queue_sched_trigger};
  assign sec_set[5] = {tif.thr[NT-1:1], tif.ovf,
    tif.trig};

  // final-frame tracking and limit crossings
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bab_end_seen_r <= 1'b0;
    end else if (broadcast_after_beacon_due) begin
      bab_end_seen_r <= 1'b0;
    end else if (broadcast_traffic_end) begin
      bab_end_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_tmo_hit_r <= 1'b0;
      cs_tmo_hit_r <= 1'b0;
    end else begin
      tx_tmo_hit_r <= tx_tmo_hit;
      cs_tmo_hit_r <= cs_tmo_hit;
    end
  end

  // clears: direct bank writes plus fan-out of primary aggregate writes
  assign prim_pw = (wr && paddr == ADDR_PRIM_FLAGS) ? pwdata : RESET_VAL;
  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      sec_clr[b] = (wr && paddr == ADDR_BANK0 + ADDR_STRIDE * b) ?
        pwdata : RESET_VAL;
    end
    sec_clr[0] = sec_clr[0] | {6'h00, {NQ{prim_pw[P_TX_DESC]}}, 6'h00,
      {NQ{prim_pw[P_TX_OK]}}};
    sec_clr[1] = sec_clr[1] | {6'h00, {NQ{prim_pw[P_TX_EOL]}}, 6'h00,
      {NQ{prim_pw[P_TX_ERR]}}};
    sec_clr[2] = sec_clr[2] | {{10{prim_pw[P_BCN_MISC]}}, 12'h000,
      {NQ{prim_pw[P_URN]}}};
    sec_clr[3] = sec_clr[3] | {6'h00, {NQ{prim_pw[P_QEMPTY]}}, 6'h00,
      {NQ{prim_pw[P_QOVF]}}};
    sec_clr[4] = sec_clr[4] | {22'h000000,
      {NQ{prim_pw[P_SCHED]}}};
    sec_clr[5] = sec_clr[5] | {32{prim_pw[P_GEN_TMR]}};
  end

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        sec_r[b] <= RESET_VAL;
      end else begin
        sec_r[b] <= ((sec_r[b] & ~sec_clr[b]) | sec_set[b]) &
          BANK_VALID[b];
      end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        sec_mask_r[b] <= RESET_VAL;
      end else if (wr && paddr == ADDR_BANK_MASK0 + ADDR_STRIDE * b) begin
        sec_mask_r[b] <= pwdata & BANK_VALID[b];
      end
    end
    assign sec_m[b] = sec_r[b] & sec_mask_r[b];
  end

  // max-rate flags take turns when both qualify in one cycle
  assign rx_max = direct_event[P_RX_MIT] && rx_max_rate_reached;
  assign tx_max = direct_event[P_TX_MIT] && tx_max_rate_reached;
  assign rx_max_win = rx_max && (!tx_max || !alt_r);
  assign tx_max_win = tx_max && (!rx_max || alt_r);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      alt_r <= 1'b0;
    end else if (rx_max_win) begin
      alt_r <= 1'b1;
    end else if (tx_max_win) begin
      alt_r <= 1'b0;
    end
  end

  always_comb begin
    direct_set = direct_event & DIRECT_MASK;
    direct_set[P_RX_MAX] = rx_max_win;
    direct_set[P_TX_MAX] = tx_max_win;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prim_direct_r <= RESET_VAL;
    end else begin
      prim_direct_r <= (prim_direct_r & ~prim_pw) | direct_set;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prim_mask_r <= RESET_VAL;
    end else if (wr && paddr == ADDR_PRIM_MASK) begin
      prim_mask_r <= pwdata;
    end
  end

  always_comb begin
    prim_val = prim_direct_r;
    prim_val[P_GEN_TMR] = |sec_m[5];
    prim_val[P_SCHED] = |sec_m[4][NQ-1:0];
    prim_val[P_QEMPTY] = |sec_m[3][Q_HI +: NQ];
    prim_val[P_QOVF] = |sec_m[3][Q_LO +: NQ];
    prim_val[P_BCN_MISC] = |sec_m[2][B2_TBTT:B2_CS_TMO];
    prim_val[P_URN] = |sec_m[2][Q_LO +: NQ];
    prim_val[P_TX_EOL] = |sec_m[1][Q_HI +: NQ];
    prim_val[P_TX_ERR] = |sec_m[1][Q_LO +: NQ];
    prim_val[P_TX_DESC] = |sec_m[0][Q_HI +: NQ];
    prim_val[P_TX_OK] = |sec_m[0][Q_LO +: NQ];
  end

  assign irq_nxt = |(prim_val & prim_mask_r);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mac_irq <= 1'b0;
    end else begin
      mac_irq <= irq_nxt;
    end
  end

  irq_follows_a: assert property (@(posedge sys_clk)
    disable iff (!reset_n) mac_irq == $past(irq_nxt))
    else $error("interrupt output disagrees with masked status");

  timer_agg_a: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    tif.trig[0] && sec_mask_r[5][0] |=> prim_val[P_GEN_TMR])
    else $error("timer trigger did not reach primary bit");

  sched_agg_a: assert property (@(posedge sys_clk)
    disable iff (!reset_n) queue_sched_trigger[0] && sec_mask_r[4][0] |=>
    prim_val[P_SCHED])
    else $error("scheduling trigger did not reach primary bit");

  mask_gate_a: assert property (@(posedge sys_clk)
    disable iff (!reset_n) sec_mask_r[0][NQ-1:0] == q0 |-> !prim_val[P_TX_OK])
    else $error("masked clean completions still aggregated");

  fanout_clear_a: assert property (@(posedge sys_clk)
    disable iff (!reset_n) prim_pw[P_TX_OK] && tx_done_clean == q0 |=>
    sec_r[0][NQ-1:0] == q0)
    else $error("primary write did not clear bank 0 flags");

  set_wins_a: assert property (@(posedge sys_clk)
    disable iff (!reset_n) sec_set[0][0] && sec_clr[0][0] |=> sec_r[0][0])
    else $error("coinciding event lost to clear");

  sticky_flag_a: assert property (@(posedge sys_clk)
    disable iff (!reset_n) sec_r[4][0] && !sec_clr[4][0] |=> sec_r[4][0])
    else $error("flag dropped without a clear");

  dmap_count_a: assert property (@(posedge sys_clk)
    disable iff (!reset_n) delivery_map_beacon && delivery_count != 8'h00 &&
    !sec_r[2][B2_DMAP] |=> !sec_r[2][B2_DMAP])
    else $error("non-zero delivery count set the flag");

  rx_max_cause_a: assert property (@(posedge sys_clk)
    disable iff (!reset_n) $rose(prim_direct_r[P_RX_MAX]) |-> $past(rx_max))
    else $error("rx max-rate flag set without cause");

  reserved_zero_a: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    sec_r[0][31:26] == 6'h00 && sec_r[4][31:10] == 22'h000000)
    else $error("reserved bank bits set");

  apb_one_wait_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
endmodule

// File: verif/wmis_event_src.sv
`timescale 1ns/1ps
// queue-side event sources: one-cycle per-queue pulses after a chosen delay
module wmis_event_src (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_kind,
  input wire logic [3:0] cmd_q,
  input wire logic [3:0] cmd_delay,
  output logic busy,
  output logic [79:0] pulses
);
  logic [3:0] wait_r;
  logic [2:0] kind_r;
  logic [3:0] q_r;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      pulses <= '0;
      wait_r <= 4'h0;
      kind_r <= 3'h0;
      q_r <= 4'h0;
    end else begin
      pulses <= '0;
      if (cmd_valid && !busy) begin
        busy <= 1'b1;
        wait_r <= cmd_delay;
        kind_r <= cmd_kind;
        q_r <= cmd_q;
      end else if (busy && wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        pulses[int'(kind_r) * 10 + int'(q_r)] <= 1'b1;
      end
    end
  end
endmodule

// File: verif/wmis_irq_status_test.sv
`timescale 1ns/1ps
module wmis_irq_status_test;
  import wmis_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, mac_irq, busy;
  logic [31:0] dev = 32'h0;
  logic rx_mr = 1'b0;
  logic tx_mr = 1'b0;
  logic [79:0] pl;
  logic [9:0] tb_clean = 10'h000;
  logic bt = 1'b0, tso = 1'b0, dmb = 1'b0, bab = 1'b0, bwe = 1'b0;
  logic bwt = 1'b0, dsl = 1'b0, bte = 1'b0, tmh = 1'b0;
  logic [7:0] dcnt = 8'h00;
  logic [15:0] gtc = 16'h0000, gtl = 16'h0010;
  logic [15:0] csc = 16'h0000, csl = 16'h0010;
  logic [31:0] ts = 32'h0, gmar = 32'h0;
  logic [511:0] gtmr = '0, gper = '0;
  logic [15:0] gen = 16'h0000;
  logic cv = 1'b0;
  logic [2:0] ck = 3'h0;
  logic [3:0] cq = 4'h0, cd = 4'h0;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int bank_t[8] = '{0, 0, 1, 1, 2, 3, 3, 4};
  int pos_t[8] = '{0, 16, 0, 16, 0, 16, 0, 0};
  int pbit_t[8] = '{P_TX_OK, P_TX_DESC, P_TX_ERR, P_TX_EOL, P_URN, P_QEMPTY,
    P_QOVF, P_SCHED};

  always #50 sys_clk = ~sys_clk;

  wmis_event_src u_src (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_valid(cv),
    .cmd_kind(ck), .cmd_q(cq), .cmd_delay(cd), .busy(busy), .pulses(pl));

  wmis_irq_status u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mac_irq(mac_irq),
    .direct_event(dev), .rx_max_rate_reached(rx_mr),
    .tx_max_rate_reached(tx_mr), .tx_done_clean(pl[9:0] | tb_clean),
    .tx_requested_done(pl[19:10]), .tx_done_with_error(pl[29:20]),
    .tx_descriptors_exhausted(pl[39:30]), .tx_fifo_underrun(pl[49:40]),
    .queue_empty_trigger(pl[59:50]), .queue_expired_overflow(pl[69:60]),
    .queue_sched_trigger(pl[79:70]), .beacon_time_timer_expired(bt),
    .timestamp_out_of_range(tso), .delivery_map_beacon(dmb),
    .delivery_count(dcnt), .broadcast_after_beacon_due(bab),
    .broadcast_wait_expired(bwe), .beacon_wait_timeout(bwt),
    .delivery_map_sync_lost(dsl), .broadcast_traffic_end(bte),
    .traffic_map_hit(tmh), .global_tx_count(gtc), .global_tx_limit(gtl),
    .carrier_sense_count(csc), .carrier_sense_limit(csl), .timestamp(ts),
    .general_timer(gtmr), .general_timer_period(gper),
    .general_timer_late_margin(gmar), .general_timer_enable(gen));

  task automatic end_of_test;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    cmp_count++;
    if (act !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, act, exp);
    end
  endtask

  // one APB transfer; for a read d is the expected data
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic err, input logic coll);
    int n;
    n = 0;
    exp_q.push_back({!w, err, w ? 32'h0 : d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge sys_clk);
    penable <= 1'b1;
    if (coll) tb_clean <= 10'h001;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    tb_clean <= 10'h000;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    apb(1'b0, a, x, 1'b0, 1'b0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 1'b0);
  endtask

  task automatic fire(input int k, input int q);
    int n;
    n = 0;
    ck <= 3'(k);
    cq <= 4'(q);
    cd <= 4'($urandom_range(3, 0));
    cv <= 1'b1;
    @(posedge sys_clk);
    cv <= 1'b0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (busy !== 1'b0 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    @(posedge sys_clk);
  endtask

  task automatic pulse(input logic [31:0] d);
    dev <= d;
    @(posedge sys_clk);
    dev <= 32'h0;
    @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      e = exp_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[32]});
      if (e[33]) chk(prdata, e[31:0]);
    end
  end

  initial begin
    int k;
    int q;
    int seed;
    logic [31:0] d;
    logic [31:0] ba;
    logic [31:0] ma;
    seed = $urandom(32194);
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(ADDR_PRIM_FLAGS, RESET_VAL);
    for (k = 0; k < NUM_BANKS; k++) begin
      rd(ADDR_BANK0 + 32'(4 * k), RESET_VAL);
    end
    apb(1'b0, 32'h1000_009C, 32'h0, 1'b1, 1'b0);
    for (k = 0; k < 8; k++) begin
      q = $urandom_range(9, 0);
      ba = ADDR_BANK0 + 32'(4 * bank_t[k]);
      ma = ADDR_BANK_MASK0 + 32'(4 * bank_t[k]);
      fire(k, q);
      d = 32'h1 << (pos_t[k] + q);
      rd(ba, d);
      rd(ADDR_PRIM_FLAGS, 32'h0);
      wr(ma, 32'hFFFF_FFFF);
      d = 32'h1 << pbit_t[k];
      rd(ADDR_PRIM_FLAGS, d);
      wr(ADDR_PRIM_FLAGS, d);
      rd(ba, 32'h0);
      wr(ma, 32'h0);
    end
    wr(ADDR_BANK_MASK0 + 32'h10, 32'hFFFF_FFFF);
    fire(7, 0);
    rd(ADDR_PRIM_FLAGS, 32'h1 << P_SCHED);
    wr(ADDR_PRIM_FLAGS, 32'hFFFF_FFFF);
    wr(ADDR_BANK_MASK0 + 32'h10, 32'h0);
    {bt, tso, bwt, dsl, tmh, dmb, bab} <= 7'h7F;
    dcnt <= 8'h03;
    @(posedge sys_clk);
    {bt, tso, bwt, dsl, tmh, dmb, bab} <= 7'h00;
    bte <= 1'b1;
    @(posedge sys_clk);
    bte <= 1'b0;
    bwe <= 1'b1;
    @(posedge sys_clk);
    bwe <= 1'b0;
    rd(ADDR_BANK2, 32'hCF00_0000);
    dmb <= 1'b1;
    dcnt <= 8'h00;
    bab <= 1'b1;
    gtc <= 16'h0010;
    csc <= 16'h0011;
    @(posedge sys_clk);
    dmb <= 1'b0;
    bab <= 1'b0;
    bwe <= 1'b1;
    @(posedge sys_clk);
    bwe <= 1'b0;
    rd(ADDR_BANK2, 32'hFFC0_0000);
    wr(ADDR_BANK_MASK0 + 32'h8, 32'hFFFF_FFFF);
    rd(ADDR_PRIM_FLAGS, 32'h1 << P_BCN_MISC);
    wr(ADDR_PRIM_FLAGS, 32'h1 << P_BCN_MISC);
    rd(ADDR_BANK2, 32'h0);
    wr(ADDR_BANK_MASK0 + 32'h8, 32'h0);
    gtmr[63:0] <= {32'd50, 32'd100};
    gper[63:0] <= {32'd1000, 32'h0010_0000};
    gmar <= 32'd10;
    ts <= 32'd20;
    @(posedge sys_clk);
    gen <= 16'h0003;
    rd(ADDR_BANK5, 32'h0);
    wr(ADDR_BANK_MASK0 + 32'h14, 32'hFFFF_FFFF);
    ts <= 32'd100;
    @(posedge sys_clk);
    rd(ADDR_BANK5, 32'h0002_0003);
    ts <= 32'd2000;
    @(posedge sys_clk);
    rd(ADDR_BANK5, 32'h0003_0003);
    rd(ADDR_PRIM_FLAGS, 32'h1 << P_GEN_TMR);
    wr(ADDR_PRIM_FLAGS, 32'h1 << P_GEN_TMR);
    rd(ADDR_BANK5, 32'h0);
    wr(ADDR_BANK_MASK0 + 32'h14, 32'h0);
    d = ($urandom | 32'h0017_C03F) & DIRECT_MASK & 32'h3FFF_FFFF;
    pulse(d);
    rd(ADDR_PRIM_FLAGS, d);
    rd(ADDR_PRIM_FLAGS, d);
    wr(ADDR_PRIM_FLAGS, 32'hFFFF_FFFF);
    rd(ADDR_PRIM_FLAGS, 32'h0);
    rx_mr <= 1'b1;
    pulse(32'h8000_0000);
    rd(ADDR_PRIM_FLAGS, 32'h8100_0000);
    wr(ADDR_PRIM_FLAGS, 32'hFFFF_FFFF);
    rx_mr <= 1'b0;
    tx_mr <= 1'b1;
    pulse(32'h4000_0000);
    rd(ADDR_PRIM_FLAGS, 32'h4008_0000);
    wr(ADDR_PRIM_FLAGS, 32'hFFFF_FFFF);
    {rx_mr, tx_mr} <= 2'b11;
    pulse(32'hC000_0000);
    rd(ADDR_PRIM_FLAGS, 32'hC100_0000);
    wr(ADDR_PRIM_FLAGS, 32'hFFFF_FFFF);
    pulse(32'hC000_0000);
    rd(ADDR_PRIM_FLAGS, 32'hC008_0000);
    wr(ADDR_PRIM_FLAGS, 32'hFFFF_FFFF);
    {rx_mr, tx_mr} <= 2'b00;
    wr(ADDR_PRIM_MASK, 32'h0000_0001);
    pulse(32'h0000_0001);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({31'h0, mac_irq}, 32'h1);
    wr(ADDR_PRIM_FLAGS, 32'h0000_0001);
    @(negedge sys_clk);
    chk({31'h0, mac_irq}, 32'h0);
    fire(0, 0);
    apb(1'b1, ADDR_BANK0, 32'h1, 1'b0, 1'b1);
    rd(ADDR_BANK0, 32'h1);
    wr(ADDR_BANK0, 32'h1);
    rd(ADDR_BANK0, 32'h0);
    fire(0, 0);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(ADDR_BANK0, RESET_VAL);
    repeat (2) @(posedge sys_clk);
    end_of_test();
  end
endmodule
